// [logic/sam_pkg.sv]
// status and alarm monitor: register map, field layout, types
// assumes: shared by the monitor top and its alarm engines
package sam_pkg;

  // ==========================================================
  // register word addresses on the serial port
  localparam logic [6:0]  ADDR_FLASH_COUNT = 7'h00;
  localparam logic [6:0]  ADDR_ALM1_THR    = 7'h20;
  localparam logic [6:0]  ADDR_ALM2_THR    = 7'h22;
  localparam logic [6:0]  ADDR_ALM1_CNT    = 7'h24;
  localparam logic [6:0]  ADDR_ALM2_CNT    = 7'h26;
  localparam logic [6:0]  ADDR_ALM_CFG     = 7'h28;
  localparam logic [6:0]  ADDR_STATUS      = 7'h3C;

  // ==========================================================
  // status word bit positions and masks
  localparam int          ST_SUPPLY_LOW    = 0;
  localparam int          ST_SUPPLY_HIGH   = 1;
  localparam int          ST_UPDATE_FAIL   = 2;
  localparam int          ST_COMM_FAIL     = 3;
  localparam int          ST_RATE_RANGE    = 4;
  localparam int          ST_SELF_TEST     = 5;
  localparam int          ST_ALARM_ONE     = 8;
  localparam int          ST_ALARM_TWO     = 9;
  localparam logic [15:0] STICKY_MASK      = 16'h032C;
  localparam logic [15:0] RESET_WORD       = 16'h0000;
  localparam logic [15:0] THR_MASK         = 16'hBFFF;
  localparam logic [15:0] CNT_MASK         = 16'h00FF;
  localparam logic [15:0] CFG_MASK         = 16'h7F7F;

  // ==========================================================
  // field widths, counts
  localparam int          THR_DIR_BIT      = 15;
  localparam int          DATA_W           = 14;
  localparam int          CNT_W            = 8;
  localparam int          ACC_W            = 24;
  localparam int          FLASH_W          = 15;
  localparam logic [14:0] FLASH_COUNT_MAX  = 15'h7FFF;
  localparam logic [3:0]  FRAME_LAST       = 4'hF;
  localparam int          SOURCE_COUNT     = 16;

  // ==========================================================
  // types
  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } sam_frame_t;

  typedef struct packed {
    logic       spare;
    logic       pin_enable;
    logic       dynamic;
    logic       filtered;
    logic [3:0] source;
  } sam_alarm_cfg_t;

  typedef enum logic [0:0] {ENG_EMPTY, ENG_RUN} sam_eng_state_t;

endpackage

// [logic/sam_sync.sv]
// two-flop level synchroniser, one stage pair per bit
// assumes: inputs are levels from another clock or from pins
`timescale 1ns/100ps
`default_nettype none
module sam_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================
  // first stage is read by the second stage only
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule // sam_sync
`default_nettype wire

// [logic/sam_alarm_engine.sv]
// one alarm engine: static compare or averaged rate of change
// assumes: update is a one-cycle pulse with sample already selected
`timescale 1ns/100ps
`default_nettype none
module sam_alarm_engine (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        update,
  input  wire logic [13:0] sample,
  input  wire logic        dynamic,
  input  wire logic [15:0] threshold,
  input  wire logic [7:0]  sample_count,
  output logic             active
);

  // ==========================================================
  // arithmetic; mean vs threshold is done as sum vs thr*n, no divider
  sam_pkg::sam_eng_state_t state;
  logic signed [13:0] prev;
  logic signed [23:0] sum;
  logic        [7:0]  n_done;
  wire  signed [13:0] smp_s   = sample;
  wire  signed [13:0] thr_s   = threshold[sam_pkg::DATA_W-1:0];
  wire                greater = threshold[sam_pkg::THR_DIR_BIT];
  wire         [7:0]  limit   = (sample_count == 8'h00) ? 8'h01 : sample_count;
  wire  signed [23:0] delta   = 24'(smp_s) - 24'(prev);
  wire  signed [23:0] next_sum = sum + delta;
  wire  signed [23:0] thr_x_n = 24'(thr_s) * $signed({16'h0000, limit});
  wire                last    = (n_done + 8'h01) == limit;
  wire                stat_hit = greater ? (smp_s > thr_s) : (smp_s < thr_s);
  wire                dyn_hit  = greater ? (next_sum > thr_x_n) : (next_sum < thr_x_n);

  // ==========================================================
  // leaving dynamic mode drops history so a stale delta never counts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state  <= sam_pkg::ENG_EMPTY;
      prev   <= '0;
      sum    <= '0;
      n_done <= 8'h00;
      active <= 1'b0;
    end else if (!dynamic) begin
      state <= sam_pkg::ENG_EMPTY;
      if (update) active <= stat_hit;
    end else if (update) begin
      prev <= smp_s;
      case (state)
        sam_pkg::ENG_EMPTY: begin
          state  <= sam_pkg::ENG_RUN;
          sum    <= '0;
          n_done <= 8'h00;
        end
        sam_pkg::ENG_RUN: begin
          sum    <= last ? 24'h000000 : next_sum;
          n_done <= last ? 8'h00 : n_done + 8'h01;
          if (last) active <= dyn_hit;
        end
        default: state <= sam_pkg::ENG_EMPTY;
      endcase
    end
  end

  // ==========================================================
  // checks
  a_static_follows: assert property (@(posedge clk) disable iff (rst)
    (update && !dynamic) |=> (active == $past(stat_hit)))
    else $error("static alarm did not follow comparison");
  a_dyn_holds: assert property (@(posedge clk) disable iff (rst)
    (dynamic && $past(dynamic) && !update) |=> $stable(active))
    else $error("dynamic alarm changed without a sample");

endmodule // sam_alarm_engine
`default_nettype wire

// [logic/sam_monitor.sv]
// status, flash write count and dual alarm monitor with serial access
// assumes: serial clock idles high, data sampled on its rising edge;
// sample data, flash and self-test strobes come from logic on clk
//
// How it works
// - supply and rate flags clear when condition ends
// - other error flags stay set until read
// - status read returns flags then clears them
// - bits nine and eight show alarm two, one
// - bit five flags self-test error
// - bit four shows rate over range
// - bit three flags serial frame failure
// - bit two flags failed control register update
// - bit one shows supply above upper limit
// - bit zero shows supply below lower limit
// - count every flash write, 32768 counts
// - count wraps to zero past maximum
// - two independent alarm engines
// - any source, filtered or unfiltered
// - static or dynamic compare per alarm
// - threshold bit 15 direction, bits 13:0 level
// - sample count bits 7:0 set average length
// - delta is new sample minus previous
// - mean delta compared against threshold
// - one shared alarm configuration register
// - data-ready beats alarm beats general pin
`timescale 1ns/100ps
`default_nettype none
module sam_monitor (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  input  wire logic        sample_update,
  input  wire logic [sam_pkg::SOURCE_COUNT-1:0][13:0] sample_raw,
  input  wire logic [sam_pkg::SOURCE_COUNT-1:0][13:0] sample_filtered,
  input  wire logic        supply_high_raw,
  input  wire logic        supply_low_raw,
  input  wire logic        rate_over_range_raw,
  input  wire logic        self_test_error,
  input  wire logic        flash_write_done,
  input  wire logic        data_ready_enable,
  input  wire logic        data_ready_line,
  input  wire logic        data_ready_level,
  input  wire logic [1:0]  gpio_direction,
  input  wire logic [1:0]  gpio_level,
  output logic             digital_pin_zero,
  output logic             digital_pin_zero_oe,
  output logic             digital_pin_one,
  output logic             digital_pin_one_oe,
  output logic [15:0]      error_flags,
  output logic [1:0]       alarm_active
);

  // ==========================================================
  // serial link, runs on the host's clock; frame end clears the counter
  wire        link_rst = rst | spi_cs_n;
  logic [3:0]  bit_cnt;
  logic [15:0] shift_in;
  logic [15:0] shift_out;
  logic [15:0] frame_word;
  logic        frame_toggle;
  logic        mid_word;
  logic [15:0] reply_word;

  // bit counter and receive shifter, cleared between frames
  always_ff @(posedge spi_sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt  <= 4'h0;
      shift_in <= 16'h0000;
    end else begin
      bit_cnt  <= bit_cnt + 4'h1;
      shift_in <= {shift_in[14:0], spi_mosi};
    end
  end

  // whole word is held until the next full word, toggle marks it
  always_ff @(posedge spi_sclk or posedge rst) begin
    if (rst) begin
      frame_word   <= 16'h0000;
      frame_toggle <= 1'b0;
      mid_word     <= 1'b0;
    end else begin
      mid_word <= (bit_cnt != sam_pkg::FRAME_LAST);
      if (bit_cnt == sam_pkg::FRAME_LAST) begin
        frame_word   <= {shift_in[14:0], spi_mosi};
        frame_toggle <= ~frame_toggle;
      end
    end
  end

  // reply loads on first falling edge; reply_word is steady by then
  // only while the host leaves a few clk cycles between frames
  always_ff @(negedge spi_sclk or posedge link_rst) begin
    if (link_rst) begin
      shift_out <= 16'h0000;
    end else if (bit_cnt == 4'h0) begin
      shift_out <= reply_word;
    end else begin
      shift_out <= {shift_out[14:0], 1'b0};
    end
  end
  assign spi_miso = shift_out[15];

  // ==========================================================
  // crossing into clk: levels through two flops
  logic [5:0] sync_q;
  sam_sync #(.WIDTH(6)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({frame_toggle, mid_word, ~spi_cs_n,
                supply_high_raw, supply_low_raw, rate_over_range_raw}),
    .sync_out (sync_q)
  );
  wire toggle_s  = sync_q[5];
  wire mid_s     = sync_q[4];
  wire cs_act_s  = sync_q[3];
  wire sup_hi_s  = sync_q[2];
  wire sup_lo_s  = sync_q[1];
  wire rate_s    = sync_q[0];

  logic toggle_d;
  logic cs_act_d;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      toggle_d    <= 1'b0;
      cs_act_d    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      toggle_d    <= toggle_s;
      cs_act_d    <= cs_act_s;
      spi_miso_oe <= cs_act_s;
    end
  end

  // ==========================================================
  // frame decode
  sam_pkg::sam_frame_t frame;
  assign frame = frame_word;
  wire       frame_pulse = toggle_s ^ toggle_d;
  wire       wr_evt      = frame_pulse & frame.write;
  wire       rd_evt      = frame_pulse & ~frame.write;
  wire [6:0] addr_word   = {frame.addr[6:1], 1'b0};
  wire       hi_byte     = frame.addr[0];
  wire       hit_flash   = addr_word == sam_pkg::ADDR_FLASH_COUNT;
  wire       hit_thr1    = addr_word == sam_pkg::ADDR_ALM1_THR;
  wire       hit_thr2    = addr_word == sam_pkg::ADDR_ALM2_THR;
  wire       hit_cnt1    = addr_word == sam_pkg::ADDR_ALM1_CNT;
  wire       hit_cnt2    = addr_word == sam_pkg::ADDR_ALM2_CNT;
  wire       hit_cfg     = addr_word == sam_pkg::ADDR_ALM_CFG;
  wire       hit_status  = addr_word == sam_pkg::ADDR_STATUS;
  wire       hit_rw      = hit_thr1 | hit_thr2 | hit_cnt1 | hit_cnt2 | hit_cfg;
  // a frame cut short or a write that cannot land counts as a failure
  wire       comm_fail_evt = cs_act_d & ~cs_act_s & mid_s;
  wire       update_fail_evt = wr_evt & ~hit_rw;
  wire       status_read   = rd_evt & hit_status;

  // ==========================================================
  // writable registers, one byte per write frame
  logic [15:0] alarm_one_threshold;
  logic [15:0] alarm_two_threshold;
  logic [15:0] alarm_one_sample_count;
  logic [15:0] alarm_two_sample_count;
  logic [15:0] alarm_configuration;

  function automatic logic [15:0] merge_byte(input logic [15:0] old, input logic hi, input logic [7:0] d);
    merge_byte = hi ? {d, old[7:0]} : {old[15:8], d};
  endfunction

  // unused bits are masked so they always read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_one_threshold    <= sam_pkg::RESET_WORD;
      alarm_two_threshold    <= sam_pkg::RESET_WORD;
      alarm_one_sample_count <= sam_pkg::RESET_WORD;
      alarm_two_sample_count <= sam_pkg::RESET_WORD;
      alarm_configuration    <= sam_pkg::RESET_WORD;
    end else if (wr_evt) begin
      if (hit_thr1) alarm_one_threshold    <= merge_byte(alarm_one_threshold, hi_byte, frame.data) & sam_pkg::THR_MASK;
      if (hit_thr2) alarm_two_threshold    <= merge_byte(alarm_two_threshold, hi_byte, frame.data) & sam_pkg::THR_MASK;
      if (hit_cnt1) alarm_one_sample_count <=
                      merge_byte(alarm_one_sample_count, hi_byte, frame.data) & sam_pkg::CNT_MASK;
      if (hit_cnt2) alarm_two_sample_count <=
                      merge_byte(alarm_two_sample_count, hi_byte, frame.data) & sam_pkg::CNT_MASK;
      if (hit_cfg)  alarm_configuration    <=
                      merge_byte(alarm_configuration, hi_byte, frame.data) & sam_pkg::CFG_MASK;
    end
  end

  // ==========================================================
  // flash write counter, wraps after the last count
  logic [14:0] flash_write_count;
  wire  [14:0] next_flash = (flash_write_count == sam_pkg::FLASH_COUNT_MAX) ? 15'h0000
                          : flash_write_count + 15'h0001;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) flash_write_count <= 15'h0000;
    else if (flash_write_done) flash_write_count <= next_flash;
  end

  // ==========================================================
  // status word: live bits follow their condition, sticky bits hold;
  // an event in the clearing cycle is kept since sets are or-ed last
  wire [15:0] set_vec = (16'(alarm_active[1]) << sam_pkg::ST_ALARM_TWO)
                      | (16'(alarm_active[0]) << sam_pkg::ST_ALARM_ONE)
                      | (16'(self_test_error) << sam_pkg::ST_SELF_TEST)
                      | (16'(comm_fail_evt)   << sam_pkg::ST_COMM_FAIL)
                      | (16'(update_fail_evt) << sam_pkg::ST_UPDATE_FAIL);
  wire [15:0] live_vec = (16'(rate_s)   << sam_pkg::ST_RATE_RANGE)
                       | (16'(sup_hi_s) << sam_pkg::ST_SUPPLY_HIGH)
                       | (16'(sup_lo_s) << sam_pkg::ST_SUPPLY_LOW);
  wire [15:0] kept     = status_read ? sam_pkg::RESET_WORD : error_flags;
  wire [15:0] next_flags = (kept & sam_pkg::STICKY_MASK) | set_vec | live_vec;

  // ==========================================================
  // read mux; unmapped addresses answer zero
  wire [15:0] read_word = hit_flash  ? {1'b0, flash_write_count}
                        : hit_thr1   ? alarm_one_threshold
                        : hit_thr2   ? alarm_two_threshold
                        : hit_cnt1   ? alarm_one_sample_count
                        : hit_cnt2   ? alarm_two_sample_count
                        : hit_cfg    ? alarm_configuration
                        : hit_status ? error_flags
                        : 16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      error_flags <= sam_pkg::RESET_WORD;
      reply_word  <= 16'h0000;
    end else begin
      error_flags <= next_flags;
      if (rd_evt) reply_word <= read_word;
    end
  end

  // ==========================================================
  // per alarm: engine plus its pin, alarm one on pin zero
  logic [1:0] alarm_w;
  assign alarm_active = alarm_w;
  genvar i;
  for (i = 0; i < 2; i++) begin : g_alarm
    sam_pkg::sam_alarm_cfg_t cfg;
    logic [15:0] thr;
    logic [7:0]  cnt;
    logic [13:0] smp;
    logic        pin_q;
    logic        pin_oe_q;
    assign cfg = alarm_configuration[i*8 +: 8];
    assign thr = (i == 0) ? alarm_one_threshold : alarm_two_threshold;
    assign cnt = (i == 0) ? alarm_one_sample_count[7:0] : alarm_two_sample_count[7:0];
    assign smp = cfg.filtered ? sample_filtered[cfg.source] : sample_raw[cfg.source];

    sam_alarm_engine u_engine (
      .clk          (clk),
      .rst          (rst),
      .update       (sample_update),
      .sample       (smp),
      .dynamic      (cfg.dynamic),
      .threshold    (thr),
      .sample_count (cnt),
      .active       (alarm_w[i])
    );

    // data-ready first, then alarm, then plain pin control
    wire drdy_here = data_ready_enable & (data_ready_line == 1'(i));
    wire next_pin  = drdy_here ? data_ready_level
                   : cfg.pin_enable ? alarm_w[i] : gpio_level[i];
    wire next_oe   = drdy_here | cfg.pin_enable | gpio_direction[i];
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pin_q    <= 1'b0;
        pin_oe_q <= 1'b0;
      end else begin
        pin_q    <= next_pin;
        pin_oe_q <= next_oe;
      end
    end
  end
  assign digital_pin_zero    = g_alarm[0].pin_q;
  assign digital_pin_zero_oe = g_alarm[0].pin_oe_q;
  assign digital_pin_one     = g_alarm[1].pin_q;
  assign digital_pin_one_oe  = g_alarm[1].pin_oe_q;

  // ==========================================================
  // checks
  a_supply_high_live: assert property (@(posedge clk) disable iff (rst)
    supply_high_raw [*4] |=> error_flags[sam_pkg::ST_SUPPLY_HIGH])
    else $error("supply high flag not set");
  a_supply_low_clear: assert property (@(posedge clk) disable iff (rst)
    (!supply_low_raw) [*4] |=> !error_flags[sam_pkg::ST_SUPPLY_LOW])
    else $error("supply low flag not cleared");
  a_rate_live: assert property (@(posedge clk) disable iff (rst)
    (!rate_over_range_raw) [*4] |=> !error_flags[sam_pkg::ST_RATE_RANGE])
    else $error("rate flag not cleared");
  a_read_clears: assert property (@(posedge clk) disable iff (rst)
    (status_read && set_vec == 16'h0000) |=> ((error_flags & sam_pkg::STICKY_MASK) == 16'h0000))
    else $error("status read did not clear sticky bits");
  a_read_returns: assert property (@(posedge clk) disable iff (rst)
    status_read |=> (reply_word == $past(error_flags)))
    else $error("status read returned wrong word");
  a_sticky_hold: assert property (@(posedge clk) disable iff (rst)
    (error_flags[sam_pkg::ST_SELF_TEST] && !status_read) |=> error_flags[sam_pkg::ST_SELF_TEST])
    else $error("sticky flag dropped without read");
  a_comm_set: assert property (@(posedge clk) disable iff (rst)
    comm_fail_evt |=> error_flags[sam_pkg::ST_COMM_FAIL])
    else $error("frame failure not flagged");
  a_update_fail: assert property (@(posedge clk) disable iff (rst)
    (wr_evt && (hit_flash || hit_status)) |=> error_flags[sam_pkg::ST_UPDATE_FAIL])
    else $error("read-only write not flagged");
  a_flash_wrap: assert property (@(posedge clk) disable iff (rst)
    (flash_write_done && flash_write_count == sam_pkg::FLASH_COUNT_MAX) |=> (flash_write_count == 15'h0000))
    else $error("flash counter did not wrap");
  a_flash_step: assert property (@(posedge clk) disable iff (rst)
    (flash_write_done && flash_write_count != sam_pkg::FLASH_COUNT_MAX)
      |=> (flash_write_count == $past(flash_write_count) + 15'h0001))
    else $error("flash counter did not step");
  a_alarm_status: assert property (@(posedge clk) disable iff (rst)
    alarm_active[1] |=> error_flags[sam_pkg::ST_ALARM_TWO])
    else $error("alarm two not shown in status");
  a_pin_priority: assert property (@(posedge clk) disable iff (rst)
    (data_ready_enable && !data_ready_line) |=> (digital_pin_zero_oe && digital_pin_zero == $past(data_ready_level)))
    else $error("data-ready lost pin priority");
  a_alarm_one_status: assert property (@(posedge clk) disable iff (rst)
    alarm_active[0] |=> error_flags[sam_pkg::ST_ALARM_ONE])
    else $error("alarm one not shown in status");
  a_self_test_set: assert property (@(posedge clk) disable iff (rst)
    self_test_error |=> error_flags[sam_pkg::ST_SELF_TEST])
    else $error("self-test error not flagged");
  a_rate_set: assert property (@(posedge clk) disable iff (rst)
    rate_over_range_raw [*4] |=> error_flags[sam_pkg::ST_RATE_RANGE])
    else $error("rate flag not set");
  a_supply_high_clear: assert property (@(posedge clk) disable iff (rst)
    (!supply_high_raw) [*4] |=> !error_flags[sam_pkg::ST_SUPPLY_HIGH])
    else $error("supply high flag not cleared");
  a_supply_low_set: assert property (@(posedge clk) disable iff (rst)
    supply_low_raw [*4] |=> error_flags[sam_pkg::ST_SUPPLY_LOW])
    else $error("supply low flag not set");
  a_alarm_pin: assert property (@(posedge clk) disable iff (rst)
    (!data_ready_enable && g_alarm[0].cfg.pin_enable)
      |=> (digital_pin_zero_oe && digital_pin_zero == $past(alarm_active[0])))
    else $error("alarm lost the pin to plain control");

endmodule // sam_monitor
`default_nettype wire

// [verif/sam_host.sv]
// serial host model: sends frames, samples replies on rising edge
// assumes: 12 ns link clock that stands still between frames
`timescale 1ns/100ps
`default_nettype none
module sam_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // n bits msb first; n below 16 makes a broken frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      #6 sclk = 1'b0;
      mosi = w[i];
      #6 sclk = 1'b1;
      r[i] = miso;
    end
    #6 cs_n = 1'b1;
    mosi = ~mosi; // released line never holds a stale bit
    #120; // gap well past the decode time
  endtask
endmodule // sam_host
`default_nettype wire

// [verif/test_sam_monitor.sv]
// bench for the status and alarm monitor, random plus corner cases
// assumes: host model on the serial port, 100 MHz system clock
`timescale 1ns/100ps
`default_nettype none
module test_sam_monitor;
  logic clk, rst, sclk, cs_n, mosi, miso, upd, shi, slo, rate, ste, fwd, dre, drl, drv, p0, p0oe, e1, e2;
  logic p1, p1oe, moe;
  logic [1:0] gdir, glvl, act;
  logic [3:0] s1, s2;
  logic [15:0] flags, r, d, t1, t2;
  logic [sam_pkg::SOURCE_COUNT-1:0][13:0] raw, filt;
  int bad_count = 0;
  int cmp_count = 0;
  sam_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  sam_monitor uut (.clk(clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(moe), .sample_update(upd), .sample_raw(raw), .sample_filtered(filt),
    .supply_high_raw(shi), .supply_low_raw(slo), .rate_over_range_raw(rate), .self_test_error(ste),
    .flash_write_done(fwd), .data_ready_enable(dre), .data_ready_line(drl), .data_ready_level(drv),
    .gpio_direction(gdir), .gpio_level(glvl), .digital_pin_zero(p0), .digital_pin_zero_oe(p0oe),
    .digital_pin_one(p1), .digital_pin_one_oe(p1oe), .error_flags(flags), .alarm_active(act));
  // ==========================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    host.xfer({1'b1, a | 7'h01, v[15:8]}, 16, r);
    host.xfer({1'b1, a, v[7:0]}, 16, r);
  endtask
  // reply comes back on the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    host.xfer({1'b0, a, 8'h00}, 16, v);
    host.xfer(16'h0000, 16, v);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tick;
    upd <= 1'b1;
    cyc(1);
    upd <= 1'b0;
    cyc(3);
  endtask
  function automatic logic hit(input logic [13:0] s, input logic [15:0] t);
    return t[15] ? $signed(s) > $signed(t[13:0]) : $signed(s) < $signed(t[13:0]);
  endfunction
  task automatic close_out;
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always #5 clk = ~clk;
  // watchdog well beyond the flash wrap run
  initial begin
    #900000;
    bad_count++;
    close_out;
  end
  // ==========================================
  // main sequence
  initial begin
    {clk, upd, shi, slo, rate, ste, fwd, dre, drl, drv, gdir, glvl} = '0;
    raw = '0;
    filt = '0;
    rst = 1'b1;
    void'($urandom(74645));
    cyc(16);
    rst <= 1'b0;
    cyc(4);
    check(flags, sam_pkg::RESET_WORD);
    for (int i = 0; i < 5; i++) begin
      d = 16'($urandom);
      wr(7'h20 + 7'(2 * i), d);
      rd(7'h20 + 7'(2 * i), r);
      check(r, d & (i < 2 ? sam_pkg::THR_MASK : i < 4 ? sam_pkg::CNT_MASK : sam_pkg::CFG_MASK));
    end
    wr(sam_pkg::ADDR_FLASH_COUNT, 16'h1234);
    // reply driver must be on while the cut frame is still selected
    fork
      host.xfer(16'hA5A5, 9, r);
      begin
        cyc(8);
        check({15'h0000, moe}, 16'h0001);
      end
    join
    cyc(10);
    check(flags & 16'h000C, 16'h000C);
    check({15'h0000, moe}, 16'h0000);
    rd(sam_pkg::ADDR_STATUS, r);
    check(r & 16'h000C, 16'h000C);
    check(flags, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      {rate, shi, slo} <= 3'b001 << i;
      cyc(6);
      check(flags, 16'h0001 << (i == 2 ? 4 : i));
      {rate, shi, slo} <= 3'b000;
      cyc(6);
      check(flags, 16'h0000);
    end
    ste <= 1'b1;
    cyc(1);
    ste <= 1'b0;
    cyc(30); // result strobe already in, so a short settle stands in for the wait
    rd(sam_pkg::ADDR_STATUS, r);
    check(r, 16'h0020);
    // wrap needs the full count plus three
    repeat (32771) begin
      fwd <= 1'b1;
      cyc(1);
      fwd <= 1'b0;
      cyc(1);
    end
    rd(sam_pkg::ADDR_FLASH_COUNT, r);
    check(r, 16'h0003);
    for (int k = 0; k < 12; k++) begin
      s1 = 4'($urandom);
      s2 = 4'($urandom);
      t1 = 16'($urandom) & sam_pkg::THR_MASK;
      t2 = 16'($urandom) & sam_pkg::THR_MASK;
      wr(sam_pkg::ADDR_ALM_CFG, {4'h1, s2, 4'h4, s1});
      wr(sam_pkg::ADDR_ALM1_THR, t1);
      wr(sam_pkg::ADDR_ALM2_THR, t2);
      @(posedge clk);
      for (int j = 0; j < sam_pkg::SOURCE_COUNT; j++) begin
        raw[j] <= 14'($urandom);
        filt[j] <= 14'($urandom);
      end
      gdir <= 2'($urandom);
      glvl <= 2'($urandom);
      cyc(1);
      e1 = hit(raw[s1], t1);
      e2 = hit(filt[s2], t2);
      tick;
      check({12'h000, p0oe, p0, act}, {12'h000, 1'b1, e1, e2, e1});
      check({14'h0000, p1oe, p1}, {14'h0000, gdir[1], glvl[1]});
    end
    drv <= ~e1;
    dre <= 1'b1;
    cyc(3);
    check({15'h0000, p0}, {15'h0000, ~e1});
    // data-ready moved to pin one hands pin zero back to the alarm
    drl <= 1'b1;
    cyc(3);
    check({14'h0000, p1, p0}, {14'h0000, ~e1, e1});
    wr(sam_pkg::ADDR_ALM1_CNT, 16'h0002);
    wr(sam_pkg::ADDR_ALM1_THR, 16'h8005);
    wr(sam_pkg::ADDR_ALM_CFG, 16'h0020);
    // deltas 10,10 give mean above five, then 1,1 below it
    for (int k = 0; k < 5; k++) begin
      raw[0] <= 14'(k < 3 ? 10 * k : 18 + k);
      cyc(1);
      tick;
      if (k == 2 || k == 4) check({15'h0000, act[0]}, 16'(k == 2));
    end
    close_out;
  end
endmodule // test_sam_monitor
`default_nettype wire
